// ---- core/uotg_pkg.sv ----
// How it works
// R1: seven enables in the OTG enable register, one per OTG event flag.
// R2: upper byte and unused bits of each register read zero, ignore writes; main enable bit 6 keeps writes made in device mode.
// R3: stall flag set whenever a STALL handshake is sent.
// R4: resume flag set after K-state lasts 2.5 us.
// R5: idle flag set after the bus stays idle 3 ms or more.
// R6: token flag set on token done; clearing it advances the status FIFO.
// R7: frame flag set on SOF received (device) or threshold reached (host).
// R8: error summary set only by error events whose enable bit is set.
// R9: device reset flag after 2.5 us bus reset; not again until reset ends.
// R10: host attach flag when not SE0 and no activity for 2.5 us.
// R11: host detach flag on bit 0; not again until the reset state ends.
// R12: flags set by hardware, zero after reset, cleared by writing ones.
// R13: software clears flags by whole-register writes with only target ones.
// R14: each main enable bit gates the flag at the same position.
// R15: main enable bit 0 gates bus reset (device) or detach (host).
// R16: attach enable and attach flag exist only in host mode.
// R17: line-state flag when line state stable 1 ms and unlike last stable.
// R18: one interrupt, OR of all enabled flags of OTG and main registers.
// R19: mode setting selects device or host layout of the main flags.
package uotg_pkg;
   // ---------------------------------------------------------------
   // register offsets (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0] OTG_FLAGS_OFS = 8'h00;
   localparam logic [7:0] OTG_EVENT_ENABLE_OFS = 8'h04;
   localparam logic [7:0] BUS_EVENT_FLAGS_OFS = 8'h08;
   localparam logic [7:0] BUS_EVENT_ENABLE_OFS = 8'h0C;
   localparam logic [7:0] ERR_FLAGS_OFS = 8'h10;
   localparam logic [7:0] ERROR_IRQ_ENABLE_REG_OFS = 8'h14;
   localparam logic [7:0] MODE_CTRL_OFS = 8'h18;
   localparam logic [7:0] TOKEN_STATUS_FIFO_OFS = 8'h1C;
   // ---------------------------------------------------------------
   // implemented bit masks and reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] OTG_MASK = 8'hFD;
   localparam logic [7:0] BUS_MASK_HOST = 8'hFF;
   localparam logic [7:0] BUS_MASK_DEV = 8'hBF;
   localparam logic [7:0] ERR_MASK = 8'hBF;
   localparam logic [7:0] REG_RESET = 8'h00;
   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int STALL_BIT = 7;
   localparam int ATTACH_BIT = 6;
   localparam int RESUME_BIT = 5;
   localparam int IDLE_BIT = 4;
   localparam int TOKEN_BIT = 3;
   localparam int SOF_BIT = 2;
   localparam int ERR_BIT = 1;
   localparam int RESET_BIT = 0;
   localparam int HOST_MODE_BIT = 0;
   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int SHORT_HOLD_NS = 2500;
   localparam int IDLE_HOLD_US = 3000;
   localparam int MS_US = 1000;
   localparam int SHORT_HOLD_CYC = (SHORT_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int IDLE_HOLD_CYC = (IDLE_HOLD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int MS_CYC = (MS_US * 1000) / CLK_PERIOD_NS;
   localparam int TIMER_W = 20;
   // ---------------------------------------------------------------
   // bus slave states
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      UOTG_IDLE = 2'b01,
      UOTG_ACK = 2'b10
   } uotg_bus_state_type;
endpackage

// ---- core/uotg_hold_timer.sv ----
`timescale 1ns/1ps
// pulses once when cond_i has held for LIMIT cycles; rearms when cond_i drops
module uotg_hold_timer #(
   parameter int W = 20,
   parameter int LIMIT = 250
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cond_i,
   output logic done_o
);
   logic [W-1:0] cnt_reg;
   logic fired_reg;

   // -----------------------------------------------------------------
   // hold counter
   // -----------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i || !cond_i)
      begin
         cnt_reg <= '0;
         fired_reg <= 1'b0;
         done_o <= 1'b0;
      end
      else if (!fired_reg && cnt_reg == W'(LIMIT - 1))
      begin
         fired_reg <= 1'b1; // no second pulse until cond drops
         done_o <= 1'b1;
      end
      else
      begin
         cnt_reg <= fired_reg ? cnt_reg : cnt_reg + W'(1);
         done_o <= 1'b0;
      end
   end
endmodule // uotg_hold_timer

// ---- core/uotg_tick.sv ----
`timescale 1ns/1ps
// one-cycle enable every PERIOD cycles
module uotg_tick #(
   parameter int W = 20,
   parameter int PERIOD = 100000
) (
   input wire logic clk_i,
   input wire logic rst_i,
   output logic tick_o
);
   logic [W-1:0] cnt_reg;

   // -----------------------------------------------------------------
   // divider
   // -----------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cnt_reg <= '0;
         tick_o <= 1'b0;
      end
      else
      begin
         tick_o <= (cnt_reg == W'(PERIOD - 1));
         cnt_reg <= (cnt_reg == W'(PERIOD - 1)) ? '0 : cnt_reg + W'(1);
      end
   end
endmodule // uotg_tick

// ---- core/uotg_irq.sv ----
`timescale 1ns/1ps
module uotg_irq #(
   parameter int AW = 8,
   parameter int FIFO_DEPTH = 4,
   parameter int IDLE_CYC = uotg_pkg::IDLE_HOLD_CYC,
   parameter int MS_CYCLES = uotg_pkg::MS_CYC
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [AW-1:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_we_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic stall_sent_i,
   input wire logic kstate_i,
   input wire logic bus_idle_i,
   input wire logic token_done_i,
   input wire logic [7:0] token_info_i,
   input wire logic sof_rx_i,
   input wire logic sof_threshold_i,
   input wire logic [7:0] err_event_i,
   input wire logic se0_i,
   input wire logic jstate_i,
   input wire logic bus_activity_i,
   input wire logic id_change_i,
   input wire logic session_valid_chg_i,
   input wire logic session_end_chg_i,
   input wire logic vbus_valid_chg_i,
   output logic irq_o
);
   localparam int PW = $clog2(FIFO_DEPTH);

   // -----------------------------------------------------------------
   // declarations
   // -----------------------------------------------------------------
   uotg_pkg::uotg_bus_state_type state_reg;
   logic [7:0] otg_flags_reg;
   logic [7:0] otg_event_enable_reg;
   logic [7:0] bus_event_flags_reg;
   logic [7:0] bus_event_enable_reg;
   logic [7:0] err_flags_reg;
   logic [7:0] error_irq_enable_reg;
   logic host_mode_reg;
   logic [7:0] token_status_fifo [FIFO_DEPTH];
   logic [PW-1:0] wr_ptr_reg;
   logic [PW-1:0] rd_ptr_reg;
   logic [PW:0] count_reg;
   logic [1:0] ls_q_reg;
   logic [1:0] last_ls_reg;
   logic line_set_reg;
   logic wr_en;
   logic [7:0] wdat;
   logic [7:0] bus_mask;
   logic [7:0] bus_set;
   logic [7:0] otg_set;
   logic [7:0] err_set;
   logic tok_push;
   logic tok_pop;
   logic resume_done;
   logic idle_done;
   logic se0_done;
   logic attach_done;
   logic ls_done;
   logic ms_tick;
   logic [7:0] rd_next;

   // write-one-to-clear update; a set in the same cycle wins
   function automatic logic [7:0] w1c(input logic [7:0] cur, input logic [7:0] clr,
                                      input logic [7:0] set, input logic [7:0] mask);
      w1c = ((cur & ~clr) | set) & mask;
   endfunction

   // -----------------------------------------------------------------
   // duration detectors
   // -----------------------------------------------------------------
   uotg_hold_timer #(.W(uotg_pkg::TIMER_W), .LIMIT(uotg_pkg::SHORT_HOLD_CYC)) u_resume (
      .clk_i(clk_i), .rst_i(rst_i), .cond_i(kstate_i), .done_o(resume_done));
   uotg_hold_timer #(.W(uotg_pkg::TIMER_W), .LIMIT(IDLE_CYC)) u_idle (
      .clk_i(clk_i), .rst_i(rst_i), .cond_i(bus_idle_i), .done_o(idle_done));
   uotg_hold_timer #(.W(uotg_pkg::TIMER_W), .LIMIT(uotg_pkg::SHORT_HOLD_CYC)) u_se0 (
      .clk_i(clk_i), .rst_i(rst_i), .cond_i(se0_i), .done_o(se0_done));
   uotg_hold_timer #(.W(uotg_pkg::TIMER_W), .LIMIT(uotg_pkg::SHORT_HOLD_CYC)) u_attach (
      .clk_i(clk_i), .rst_i(rst_i), .cond_i(host_mode_reg && !se0_i && !bus_activity_i),
      .done_o(attach_done));
   uotg_hold_timer #(.W(uotg_pkg::TIMER_W), .LIMIT(MS_CYCLES)) u_line (
      .clk_i(clk_i), .rst_i(rst_i), .cond_i({se0_i, jstate_i} == ls_q_reg),
      .done_o(ls_done));
   uotg_tick #(.W(uotg_pkg::TIMER_W), .PERIOD(MS_CYCLES)) u_ms (
      .clk_i(clk_i), .rst_i(rst_i), .tick_o(ms_tick));

   // -----------------------------------------------------------------
   // line-state stability tracking
   // -----------------------------------------------------------------
   // R17: flag only when the stable state differs from the last one
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ls_q_reg <= 2'h0;
         last_ls_reg <= 2'h0;
         line_set_reg <= 1'b0;
      end
      else
      begin
         ls_q_reg <= {se0_i, jstate_i};
         line_set_reg <= ls_done && (ls_q_reg != last_ls_reg);
         if (ls_done)
         begin
            last_ls_reg <= ls_q_reg;
         end
      end
   end

   // -----------------------------------------------------------------
   // bus slave decode
   // -----------------------------------------------------------------
   // R2: only the low byte lane carries register bits
   assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] &&
                  state_reg == uotg_pkg::UOTG_IDLE;
   assign wdat = wb_dat_i[7:0];
   // R19: bit 6 exists only in the host layout
   assign bus_mask = host_mode_reg ? uotg_pkg::BUS_MASK_HOST : uotg_pkg::BUS_MASK_DEV;

   // -----------------------------------------------------------------
   // token status fifo
   // -----------------------------------------------------------------
   // R6: clearing the token flag pops the head entry
   assign tok_pop = wr_en && wb_adr_i == uotg_pkg::BUS_EVENT_FLAGS_OFS &&
                    wdat[uotg_pkg::TOKEN_BIT] && count_reg != '0;
   assign tok_push = token_done_i && count_reg != (PW+1)'(FIFO_DEPTH);
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end
      else
      begin
         if (tok_push)
         begin
            token_status_fifo[wr_ptr_reg] <= token_info_i;
            wr_ptr_reg <= (wr_ptr_reg == PW'(FIFO_DEPTH - 1)) ? '0 : wr_ptr_reg + PW'(1);
         end
         if (tok_pop)
         begin
            rd_ptr_reg <= (rd_ptr_reg == PW'(FIFO_DEPTH - 1)) ? '0 : rd_ptr_reg + PW'(1);
         end
         count_reg <= count_reg + (PW+1)'(tok_push) - (PW+1)'(tok_pop);
      end
   end

   // -----------------------------------------------------------------
   // event set vectors
   // -----------------------------------------------------------------
   always_comb
   begin
      err_set = err_event_i & uotg_pkg::ERR_MASK;
      otg_set = {id_change_i, ms_tick, line_set_reg, bus_activity_i,
                 session_valid_chg_i, session_end_chg_i, 1'b0, vbus_valid_chg_i};
      bus_set = 8'h00;
      // R3: stall handshake sent
      bus_set[uotg_pkg::STALL_BIT] = stall_sent_i;
      // R10: attach seen in host mode only
      bus_set[uotg_pkg::ATTACH_BIT] = attach_done && host_mode_reg;
      // R4: K-state held
      bus_set[uotg_pkg::RESUME_BIT] = resume_done;
      // R5: idle held
      bus_set[uotg_pkg::IDLE_BIT] = idle_done;
      // R6: new token, or more entries remain after a pop
      bus_set[uotg_pkg::TOKEN_BIT] = token_done_i || (tok_pop && count_reg > (PW+1)'(1));
      // R7: source of frame event depends on mode
      bus_set[uotg_pkg::SOF_BIT] = host_mode_reg ? sof_threshold_i : sof_rx_i;
      // R8: only enabled error events raise the summary
      bus_set[uotg_pkg::ERR_BIT] = |(err_set & error_irq_enable_reg);
      // R9: R11: SE0 held fires once per reset or detach episode
      bus_set[uotg_pkg::RESET_BIT] = se0_done;
   end

   // -----------------------------------------------------------------
   // flag registers
   // -----------------------------------------------------------------
   // R12: hardware sets, write of one clears
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         otg_flags_reg <= uotg_pkg::REG_RESET;
         bus_event_flags_reg <= uotg_pkg::REG_RESET;
         err_flags_reg <= uotg_pkg::REG_RESET;
      end
      else
      begin
         otg_flags_reg <= w1c(otg_flags_reg,
            (wr_en && wb_adr_i == uotg_pkg::OTG_FLAGS_OFS) ? wdat : 8'h00,
            otg_set, uotg_pkg::OTG_MASK);
         bus_event_flags_reg <= w1c(bus_event_flags_reg,
            (wr_en && wb_adr_i == uotg_pkg::BUS_EVENT_FLAGS_OFS) ? wdat : 8'h00,
            bus_set, bus_mask);
         err_flags_reg <= w1c(err_flags_reg,
            (wr_en && wb_adr_i == uotg_pkg::ERR_FLAGS_OFS) ? wdat : 8'h00,
            err_set, uotg_pkg::ERR_MASK);
      end
   end

   // -----------------------------------------------------------------
   // enable and mode registers
   // -----------------------------------------------------------------
   // R1: R14: plain read/write enables
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         otg_event_enable_reg <= uotg_pkg::REG_RESET;
         bus_event_enable_reg <= uotg_pkg::REG_RESET;
         error_irq_enable_reg <= uotg_pkg::REG_RESET;
         host_mode_reg <= 1'b0;
      end
      else if (wr_en)
      begin
         case (wb_adr_i)
            uotg_pkg::OTG_EVENT_ENABLE_OFS: otg_event_enable_reg <= wdat & uotg_pkg::OTG_MASK;
            uotg_pkg::BUS_EVENT_ENABLE_OFS: bus_event_enable_reg <= wdat;
            uotg_pkg::ERROR_IRQ_ENABLE_REG_OFS: error_irq_enable_reg <= wdat & uotg_pkg::ERR_MASK;
            uotg_pkg::MODE_CTRL_OFS: host_mode_reg <= wdat[uotg_pkg::HOST_MODE_BIT];
            default: ;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // read mux
   // -----------------------------------------------------------------
   // R16: attach enable reads zero in device mode
   always_comb
   begin
      case (wb_adr_i)
         uotg_pkg::OTG_FLAGS_OFS: rd_next = otg_flags_reg;
         uotg_pkg::OTG_EVENT_ENABLE_OFS: rd_next = otg_event_enable_reg;
         uotg_pkg::BUS_EVENT_FLAGS_OFS: rd_next = bus_event_flags_reg & bus_mask;
         uotg_pkg::BUS_EVENT_ENABLE_OFS: rd_next = bus_event_enable_reg & bus_mask;
         uotg_pkg::ERR_FLAGS_OFS: rd_next = err_flags_reg;
         uotg_pkg::ERROR_IRQ_ENABLE_REG_OFS: rd_next = error_irq_enable_reg;
         uotg_pkg::MODE_CTRL_OFS: rd_next = {7'h00, host_mode_reg};
         uotg_pkg::TOKEN_STATUS_FIFO_OFS: rd_next = (count_reg != '0) ?
                                          token_status_fifo[rd_ptr_reg] : 8'h00;
         default: rd_next = 8'h00;
      endcase
   end

   // -----------------------------------------------------------------
   // wishbone handshake, one registered ack per request (one wait state)
   // -----------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_reg <= uotg_pkg::UOTG_IDLE;
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end
      else
      begin
         case (state_reg)
            uotg_pkg::UOTG_IDLE:
            begin
               if (wb_cyc_i && wb_stb_i)
               begin
                  state_reg <= uotg_pkg::UOTG_ACK;
                  wb_ack_o <= 1'b1;
                  // R2: upper bits always zero
                  wb_dat_o <= {24'h00_0000, rd_next};
               end
            end
            uotg_pkg::UOTG_ACK:
            begin
               state_reg <= uotg_pkg::UOTG_IDLE;
               wb_ack_o <= 1'b0;
            end
            default:
            begin
               state_reg <= uotg_pkg::UOTG_IDLE;
               wb_ack_o <= 1'b0;
            end
         endcase
      end
   end

   // -----------------------------------------------------------------
   // interrupt output
   // -----------------------------------------------------------------
   // R15: R18: enabled flags of both registers OR into one level
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         irq_o <= 1'b0;
      end
      else
      begin
         irq_o <= |(otg_flags_reg & otg_event_enable_reg) |
                  |(bus_event_flags_reg & bus_event_enable_reg & bus_mask);
      end
   end

   // -----------------------------------------------------------------
   // assertions
   // -----------------------------------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   sequence s_clr_stall;
      wr_en && wb_adr_i == uotg_pkg::BUS_EVENT_FLAGS_OFS && wdat[uotg_pkg::STALL_BIT];
   endsequence
   sequence s_pop_last;
      tok_pop && count_reg == (PW+1)'(1) && !token_done_i;
   endsequence

   chk_reserved_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000) // R2
      else $error("upper read bits not zero");
   chk_stall_set: assert property (stall_sent_i |=> bus_event_flags_reg[uotg_pkg::STALL_BIT]) // R3
      else $error("stall flag not set");
   chk_w1c_clear: assert property (s_clr_stall ##0 !stall_sent_i |=> // R12
      !bus_event_flags_reg[uotg_pkg::STALL_BIT])
      else $error("stall flag not cleared by write of one");
   chk_err_masked: assert property ((err_event_i & error_irq_enable_reg) == 8'h00 && // R8
      !bus_event_flags_reg[uotg_pkg::ERR_BIT] |=> !bus_event_flags_reg[uotg_pkg::ERR_BIT])
      else $error("masked error set summary");
   chk_dev_bit6: assert property (!host_mode_reg |=> // R16
      !bus_event_flags_reg[uotg_pkg::ATTACH_BIT] || host_mode_reg)
      else $error("attach flag in device mode");
   chk_sof_dev: assert property (!host_mode_reg && sof_rx_i |=> // R7
      bus_event_flags_reg[uotg_pkg::SOF_BIT])
      else $error("frame flag not set");
   chk_token_pop: assert property (s_pop_last |=> count_reg == '0 && // R6
      !bus_event_flags_reg[uotg_pkg::TOKEN_BIT])
      else $error("token fifo did not advance");
   chk_irq_level: assert property (bus_event_flags_reg[uotg_pkg::STALL_BIT] && // R18
      bus_event_enable_reg[uotg_pkg::STALL_BIT] |=> irq_o)
      else $error("enabled flag gave no interrupt");
   chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) // one-cycle ack
      else $error("ack longer than one cycle");
endmodule // uotg_irq

// ---- dv/uotg_bus_peer.sv ----
`timescale 1ns/1ps
// ------------------------------------------------------------
// bus-side event source
// ------------------------------------------------------------
module uotg_bus_peer (
   input wire logic clk_i,
   output logic [9:0] pulse_o,
   output logic [3:0] lvl_o,
   output logic [7:0] err_o,
   output logic [7:0] info_o
);
   // quiet lines at time zero
   initial
   begin
      pulse_o = 10'h000;
      lvl_o = 4'h0;
      err_o = 8'h00;
      info_o = 8'h00;
   end
   // one-cycle event with error bits and token status; index 9 drives nothing
   // event pulses
   task automatic pulse(input int k, input logic [7:0] e, input logic [7:0] t);
      @(posedge clk_i);
      pulse_o[k] <= 1'b1;
      err_o <= e;
      info_o <= t;
      @(posedge clk_i);
      pulse_o <= 10'h000;
      err_o <= 8'h00;
      info_o <= ~t; // released status shows no stale value
   endtask
   // set a line level, then let n cycles pass
   // held line states
   task automatic lvl(input int k, input logic v, input int n);
      @(posedge clk_i);
      lvl_o[k] <= v;
      repeat (n) @(posedge clk_i);
   endtask
endmodule // uotg_bus_peer

// ---- dv/usb_otg_interrupt_flags_tb.sv ----
`timescale 1ns/1ps
module usb_otg_interrupt_flags_tb;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h00000000;
   logic [3:0] sel = 4'h0;
   logic we = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic [31:0] rdat;
   logic [31:0] r;
   logic ack;
   logic irq;
   logic [9:0] pl;
   logic [3:0] lv;
   logic [7:0] er;
   logic [7:0] inf;
   int fails = 0;
   int checks = 0;
   int ncyc = 0;
   // 100 MHz clock
   always #5 clk = ~clk;
   uotg_irq #(.IDLE_CYC(50), .MS_CYCLES(40)) i_uotg_irq (
      .clk_i(clk), .rst_i(rst), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel),
      .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack),
      .stall_sent_i(pl[0]), .kstate_i(lv[0]), .bus_idle_i(lv[1]), .token_done_i(pl[1]),
      .token_info_i(inf), .sof_rx_i(pl[2]), .sof_threshold_i(pl[3]), .err_event_i(er),
      .se0_i(lv[2]), .jstate_i(lv[3]), .bus_activity_i(pl[4]), .id_change_i(pl[5]),
      .session_valid_chg_i(pl[6]), .session_end_chg_i(pl[7]), .vbus_valid_chg_i(pl[8]),
      .irq_o(irq));
   uotg_bus_peer i_uotg_bus_peer (.clk_i(clk), .pulse_o(pl), .lvl_o(lv), .err_o(er),
      .info_o(inf));
   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic results();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // classic cycle: hold request until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
      adr <= a;
      wdat <= {24'h000000, d};
      we <= w;
      sel <= 4'hF;
      cyc <= 1'b1;
      stb <= 1'b1;
      @(posedge clk);
      while (ack !== 1'b1) @(posedge clk);
      r = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge clk);
   endtask
   task automatic chk(input logic [31:0] g, input logic [7:0] e, input logic [7:0] m);
      checks++;
      if ((g & {24'hFFFFFF, m}) !== {24'h000000, e & m})
      begin
         fails++;
         $display("[ERR] %0t read %h expected %h", $time, g, e);
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
      wb(1'b0, a, 8'h00);
      chk(r, e, m);
   endtask
   task automatic chk_irq(input logic e);
      repeat (2) @(posedge clk);
      checks++;
      if (irq !== e)
      begin
         fails++;
         $display("[ERR] %0t irq %b expected %b", $time, irq, e);
      end
   endtask
   // cycle ceiling against a hang
   always @(posedge clk)
   begin
      ncyc <= ncyc + 1;
      if (ncyc == 20000)
      begin
         fails++;
         $display("[ERR] %0t timeout", $time);
         results();
      end
   end
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial
   begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 9; i++) rd(8'(i * 4), 8'h00, (i == 0) ? 8'hBF : 8'hFF);
      $display("test reset done");
      wb(1'b1, 8'h04, 8'hFF);
      rd(8'h04, 8'hFD, 8'hFF);
      wb(1'b1, 8'h0C, 8'hFF);
      rd(8'h0C, 8'hBF, 8'hFF);
      wb(1'b1, 8'h04, 8'h00);
      wb(1'b1, 8'h0C, 8'h00);
      $display("test enables done");
      i_uotg_bus_peer.pulse(0, 8'h00, 8'h00);
      rd(8'h08, 8'h80, 8'hFF);
      i_uotg_bus_peer.pulse(2, 8'h00, 8'h00);
      rd(8'h08, 8'h84, 8'hFF);
      wb(1'b1, 8'h08, 8'h04);
      rd(8'h08, 8'h80, 8'hFF);
      wb(1'b1, 8'h08, 8'h00);
      rd(8'h08, 8'h80, 8'hFF);
      wb(1'b1, 8'h08, 8'h80);
      i_uotg_bus_peer.pulse(9, 8'h01, 8'h00);
      rd(8'h08, 8'h00, 8'hFF);
      rd(8'h10, 8'h01, 8'hFF);
      wb(1'b1, 8'h14, 8'h01);
      i_uotg_bus_peer.pulse(9, 8'h01, 8'h00);
      rd(8'h08, 8'h02, 8'hFF);
      wb(1'b1, 8'h08, 8'h02);
      i_uotg_bus_peer.pulse(9, 8'hC0, 8'h00);
      rd(8'h08, 8'h00, 8'hFF);
      rd(8'h10, 8'h81, 8'hFF);
      wb(1'b1, 8'h10, 8'hFF);
      rd(8'h10, 8'h00, 8'hFF);
      $display("test flags done");
      i_uotg_bus_peer.pulse(1, 8'h00, 8'hA1);
      i_uotg_bus_peer.pulse(1, 8'h00, 8'hB2);
      rd(8'h08, 8'h08, 8'hFF);
      rd(8'h1C, 8'hA1, 8'hFF);
      wb(1'b1, 8'h08, 8'h08);
      rd(8'h1C, 8'hB2, 8'hFF);
      rd(8'h08, 8'h08, 8'hFF);
      wb(1'b1, 8'h08, 8'h08);
      rd(8'h1C, 8'h00, 8'hFF);
      $display("test token done");
      i_uotg_bus_peer.lvl(0, 1'b1, 200);
      rd(8'h08, 8'h00, 8'hFF);
      i_uotg_bus_peer.lvl(0, 1'b1, 60);
      i_uotg_bus_peer.lvl(0, 1'b0, 0);
      rd(8'h08, 8'h20, 8'hFF);
      i_uotg_bus_peer.lvl(1, 1'b1, 60);
      i_uotg_bus_peer.lvl(1, 1'b0, 0);
      rd(8'h08, 8'h30, 8'hFF);
      wb(1'b1, 8'h08, 8'hFF);
      i_uotg_bus_peer.lvl(2, 1'b1, 260);
      rd(8'h08, 8'h01, 8'hFF);
      wb(1'b1, 8'h0C, 8'h01);
      chk_irq(1'b1);
      wb(1'b1, 8'h0C, 8'h00);
      wb(1'b1, 8'h08, 8'h01);
      i_uotg_bus_peer.lvl(2, 1'b1, 300);
      rd(8'h08, 8'h00, 8'hFF);
      i_uotg_bus_peer.lvl(2, 1'b0, 0);
      $display("test timers done");
      wb(1'b1, 8'h0C, 8'h80);
      i_uotg_bus_peer.pulse(0, 8'h00, 8'h00);
      chk_irq(1'b1);
      wb(1'b1, 8'h0C, 8'h00);
      chk_irq(1'b0);
      wb(1'b1, 8'h0C, 8'h80);
      chk_irq(1'b1);
      wb(1'b1, 8'h08, 8'h80);
      chk_irq(1'b0);
      wb(1'b1, 8'h0C, 8'h00);
      $display("test irq done");
      wb(1'b1, 8'h18, 8'h01);
      i_uotg_bus_peer.pulse(4, 8'h00, 8'h00);
      i_uotg_bus_peer.lvl(3, 1'b0, 260);
      rd(8'h08, 8'h40, 8'hFF);
      wb(1'b1, 8'h0C, 8'hFF);
      rd(8'h0C, 8'hFF, 8'hFF);
      wb(1'b1, 8'h0C, 8'h00);
      i_uotg_bus_peer.lvl(2, 1'b1, 260);
      rd(8'h08, 8'h41, 8'hFF);
      wb(1'b1, 8'h0C, 8'h01);
      chk_irq(1'b1);
      wb(1'b1, 8'h0C, 8'h00);
      wb(1'b1, 8'h08, 8'h41);
      i_uotg_bus_peer.lvl(2, 1'b1, 300);
      rd(8'h08, 8'h00, 8'hFF);
      i_uotg_bus_peer.pulse(2, 8'h00, 8'h00);
      rd(8'h08, 8'h00, 8'hFF);
      i_uotg_bus_peer.pulse(3, 8'h00, 8'h00);
      rd(8'h08, 8'h04, 8'hFF);
      wb(1'b1, 8'h08, 8'h04);
      i_uotg_bus_peer.lvl(2, 1'b0, 60);
      wb(1'b1, 8'h00, 8'hFF);
      rd(8'h00, 8'h00, 8'h20);
      i_uotg_bus_peer.lvl(3, 1'b1, 60);
      rd(8'h00, 8'h20, 8'h20);
      wb(1'b1, 8'h04, 8'h80);
      i_uotg_bus_peer.pulse(5, 8'h00, 8'h00);
      chk_irq(1'b1);
      i_uotg_bus_peer.pulse(6, 8'h00, 8'h00);
      i_uotg_bus_peer.pulse(7, 8'h00, 8'h00);
      i_uotg_bus_peer.pulse(8, 8'h00, 8'h00);
      rd(8'h00, 8'hCD, 8'hCF);
      wb(1'b1, 8'h00, 8'h80);
      chk_irq(1'b0);
      $display("test host done");
      results();
   end
endmodule // usb_otg_interrupt_flags_tb
